// ### logic/kds_defines.vh
// Constants for the keyboard and display scanner
//
// ==============================================
// Overview of operation
// [RQ1] Reset: 16-char left entry, encoded lockout, divisor 31
// [RQ2] Bus drives only on read with select
// [RQ3] Select line high means command or status
// [RQ4] Command taken on write strobe rising edge
// [RQ5] Prescaler timebase sets scan and debounce times
// [RQ6] Encoded scan: binary count, active high
// [RQ7] Decoded scan: one of four, active low
// [RQ8] Decoded keyboard forces four-digit decoded display
// [RQ9] Return lines latched, examined every row
// [RQ10] Debounce wait, then push key if held
// [RQ11] Key coded as six-bit matrix position
// [RQ12] Shift and control captured with key
// [RQ13] Sensor modes copy return lines per row
// [RQ14] Strobed mode pushes lines on strobe rise
// [RQ15] Eight-entry queue returns entries in order
// [RQ16] Count, full, empty; overrun and underrun flagged
// [RQ17] Status word read with select line high
// [RQ18] Keyboard interrupt follows queue not empty
// [RQ19] Sensor change raises the interrupt
// [RQ20] Display address with auto-increment, entry tracking
// [RQ21] Two nibble ports, low nibble is bit 0
// [RQ22] Blank during digit switching or blanking
// [RQ23] Mode set: opcode 000, display, keyboard fields
// [RQ24] Clock set: opcode 001, divisor 2 to 31
// [RQ25] Reset empties queue, clears error, irq low
`ifndef KDS_DEFINES_VH
`define KDS_DEFINES_VH
`define KDS_OP_MODE 3'h0
`define KDS_OP_CLOCK 3'h1
`define KDS_OP_RD_FIFO 3'h2
`define KDS_OP_RD_DISP 3'h3
`define KDS_OP_WR_DISP 3'h4
`define KDS_RST_DISPLAY_MODE 2'h1
`define KDS_RST_KEYBOARD_MODE 3'h0
`define KDS_RST_PRESCALE 5'h1F
`define KDS_MIN_PRESCALE 5'h02
`define KDS_TICKS_PER_ROW 6'h3F
`define KDS_BLANK_TICKS 6'h02
`define KDS_DEBOUNCE_SCANS 2'h2
`define KDS_ST_IDLE 2'h0
`define KDS_ST_DEB 2'h1
`define KDS_ST_HELD 2'h2
`endif

// ### logic/kds_top.v
// Keyboard and display scanner: entry queue and top level
`timescale 1ns/100ps
`default_nettype none
`include "kds_defines.vh"

// ==============================================
// Entry queue
module kds_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire i_core_clk,
   input wire i_reset,
   input wire i_in_valid,
   input wire [WIDTH-1:0] i_in_data,
   output wire o_in_ready,
   output wire o_out_valid,
   output wire [WIDTH-1:0] o_out_data,
   input wire i_out_ready,
   output wire [AW:0] o_count
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   wire push;
   wire pop;

   // Honest full and empty from the count
   assign o_in_ready = (cnt_r != DEPTH[AW:0]);
   assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
   assign o_out_data = mem_r[rp_r];
   assign o_count = cnt_r;
   assign push = i_in_valid & o_in_ready;
   assign pop = i_out_ready & o_out_valid;

   // Storage written at successive positions
   always @(posedge i_core_clk) begin
      if (push) begin
         mem_r[wp_r] <= i_in_data;
      end
   end

   // Pointers and count; reset empties the queue
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// ==============================================
// Scanner top
module kds_top #(
   parameter FIFO_DEPTH = 8
) (
   input wire i_core_clk,
   input wire i_reset,
   input wire i_cs_n,
   input wire i_command_data_select,
   input wire i_rd_n,
   input wire i_wr_n,
   input wire [7:0] i_data,
   output reg [7:0] o_data,
   output reg o_data_oe_n,
   input wire [7:0] i_return_line_inputs,
   input wire i_shift,
   input wire i_control_strobe_input,
   input wire i_blank_high,
   input wire i_blank_low,
   output reg [3:0] o_scan_line_outputs,
   output reg [3:0] o_display_high_nibble_port,
   output reg [3:0] o_display_low_nibble_port,
   output reg o_display_blank_output,
   output reg o_irq
);
   // First open-low return line
   function [2:0] kds_first_low;
      input [7:0] lines;
      integer k;
      begin
         kds_first_low = 3'h0;
         for (k = 7; k >= 0; k = k - 1) begin
            if (!lines[k]) begin
               kds_first_low = k[2:0];
            end
         end
      end
   endfunction

   // Decoded scan selected by keyboard mode
   function kds_is_decoded;
      input [2:0] kmode;
      begin
         kds_is_decoded = kmode[0];
      end
   endfunction

   // ==============================================
   // Input synchronisers
   wire [21:0] raw_in;
   reg [21:0] s1_r;
   reg [21:0] s2_r;
   reg [21:0] s3_r;
   assign raw_in = {i_cs_n, i_command_data_select, i_rd_n, i_wr_n, i_data,
                    i_return_line_inputs, i_shift, i_control_strobe_input};

   // Two stages, third stage only for edges
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         s1_r <= 22'h3FFFFF;
         s2_r <= 22'h3FFFFF;
         s3_r <= 22'h3FFFFF;
      end else begin
         s1_r <= raw_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   wire cs_act = ~s2_r[21];
   wire a0 = s2_r[20];
   wire rd_act = cs_act & ~s2_r[19];
   // [RQ4] rising write edge
   wire wr_rise = cs_act & s2_r[18] & ~s3_r[18];
   wire rd_rise = cs_act & s2_r[19] & ~s3_r[19];
   wire [7:0] bus_d = s2_r[17:10];
   wire [7:0] rl = s2_r[9:2];
   wire shift_s = s2_r[1];
   wire ctrl_s = s2_r[0];
   wire strobe_rise = s2_r[0] & ~s3_r[0];

   // ==============================================
   // Control registers and state
   reg [1:0] dmode_r;
   reg [2:0] kmode_r;
   reg [4:0] presc_r;
   reg rd_disp_r;
   reg ai_r;
   reg [3:0] daddr_r;
   reg [3:0] dofs_r;
   reg [2:0] saddr_r;
   reg ovr_r;
   reg und_r;
   reg sens_chg_r;
   reg [7:0] dram_r [0:15];
   reg [7:0] sram_r [0:7];
   integer si;
   reg [4:0] pcnt_r;
   reg [5:0] sub_r;
   reg [3:0] scan_r;
   reg [1:0] st_r;
   reg [2:0] krow_r;
   reg [2:0] kcol_r;
   reg [1:0] scans_r;
   reg kb_push_r;
   reg [7:0] kb_code_r;

   wire kdec = kds_is_decoded(kmode_r);
   wire kb_mode = ~kmode_r[2];
   wire sens_mode = kmode_r[2] & ~kmode_r[1];
   wire strb_mode = kmode_r[2] & kmode_r[1];
   wire tick = (pcnt_r >= presc_r - 5'h01);
   wire row_end = tick & (sub_r == `KDS_TICKS_PER_ROW);
   wire [2:0] row = kdec ? {1'b0, scan_r[1:0]} : scan_r[2:0];
   wire closed = (rl != 8'hFF);

   // [RQ15] queue feed and drain
   // [RQ14] strobe rise pushes lines
   wire fifo_in_valid = kb_push_r | (strb_mode & strobe_rise);
   wire [7:0] fifo_in_data = kb_push_r ? kb_code_r : rl;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire [3:0] fifo_count;
   wire data_pop = rd_rise & ~a0 & ~rd_disp_r & ~sens_mode;
   wire [7:0] status = {1'b0, sens_chg_r, ovr_r, und_r, ~fifo_in_ready, fifo_count[2:0]};

   kds_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_in_valid(fifo_in_valid),
      .i_in_data(fifo_in_data),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(fifo_out_valid),
      .o_out_data(fifo_out_data),
      .i_out_ready(data_pop),
      .o_count(fifo_count)
   );

   // ==============================================
   // Command and data port
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         // [RQ1] reset modes and divisor
         dmode_r <= `KDS_RST_DISPLAY_MODE;
         kmode_r <= `KDS_RST_KEYBOARD_MODE;
         presc_r <= `KDS_RST_PRESCALE;
         rd_disp_r <= 1'b0;
         ai_r <= 1'b0;
         daddr_r <= 4'h0;
         dofs_r <= 4'h0;
         saddr_r <= 3'h0;
      end else if (wr_rise & a0) begin
         // [RQ3] select high: command decode
         case (bus_d[7:5])
            `KDS_OP_MODE: begin
               // [RQ23] display and keyboard fields
               dmode_r <= bus_d[4:3];
               kmode_r <= bus_d[2:0];
            end
            `KDS_OP_CLOCK: begin
               // [RQ24] divisor range 2 to 31
               if (bus_d[4:0] >= `KDS_MIN_PRESCALE) begin
                  presc_r <= bus_d[4:0];
               end
            end
            `KDS_OP_RD_FIFO: begin
               rd_disp_r <= 1'b0;
               ai_r <= bus_d[4];
               saddr_r <= bus_d[2:0];
            end
            `KDS_OP_RD_DISP: begin
               rd_disp_r <= 1'b1;
               ai_r <= bus_d[4];
               daddr_r <= bus_d[3:0];
            end
            `KDS_OP_WR_DISP: begin
               ai_r <= bus_d[4];
               daddr_r <= bus_d[3:0];
            end
            default: begin
               ai_r <= ai_r;
            end
         endcase
      end else if (wr_rise) begin
         // [RQ20] auto-increment and right entry offset
         if (ai_r) begin
            daddr_r <= daddr_r + 4'h1;
         end
         if (dmode_r[1]) begin
            dofs_r <= dofs_r + 4'h1;
         end
      end else if (rd_rise & ~a0) begin
         if (rd_disp_r & ai_r) begin
            daddr_r <= daddr_r + 4'h1;
         end else if (~rd_disp_r & sens_mode & ai_r) begin
            saddr_r <= saddr_r + 3'h1;
         end
      end
   end

   // Display RAM written by data writes
   always @(posedge i_core_clk) begin
      if (wr_rise & ~a0) begin
         dram_r[daddr_r] <= bus_d;
      end
   end

   // [RQ2] drive only while selected read
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_data_oe_n <= 1'b1;
         o_data <= 8'h00;
      end else begin
         o_data_oe_n <= ~rd_act;
         if (rd_act) begin
            // [RQ17] status with select high
            if (a0) begin
               o_data <= status;
            end else if (rd_disp_r) begin
               o_data <= dram_r[daddr_r];
            end else if (sens_mode) begin
               o_data <= sram_r[saddr_r];
            end else begin
               o_data <= fifo_out_data;
            end
         end
      end
   end

   // ==============================================
   // Timing chain
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         pcnt_r <= 5'h00;
         sub_r <= 6'h00;
         scan_r <= 4'h0;
      end else begin
         // [RQ5] prescaler then row and scan counters
         pcnt_r <= tick ? 5'h00 : pcnt_r + 5'h01;
         if (tick) begin
            sub_r <= (sub_r == `KDS_TICKS_PER_ROW) ? 6'h00 : sub_r + 6'h01;
         end
         if (row_end) begin
            scan_r <= scan_r + 4'h1;
         end
      end
   end

   // ==============================================
   // Key debounce
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         st_r <= `KDS_ST_IDLE;
         krow_r <= 3'h0;
         kcol_r <= 3'h0;
         scans_r <= 2'h0;
         kb_push_r <= 1'b0;
         kb_code_r <= 8'h00;
      end else begin
         kb_push_r <= 1'b0;
         // [RQ9] return lines examined each row
         if (row_end & kb_mode) begin
            case (st_r)
               `KDS_ST_IDLE: begin
                  if (closed) begin
                     krow_r <= row;
                     kcol_r <= kds_first_low(rl);
                     scans_r <= 2'h0;
                     st_r <= `KDS_ST_DEB;
                  end
               end
               `KDS_ST_DEB: begin
                  if (~kmode_r[1] & closed &
                      ((row != krow_r) | (rl != ~(8'h01 << kcol_r)))) begin
                     st_r <= `KDS_ST_IDLE;
                  end else if (row == krow_r) begin
                     scans_r <= scans_r + 2'h1;
                     // [RQ10] push if still closed
                     if (scans_r + 2'h1 == `KDS_DEBOUNCE_SCANS) begin
                        if (!rl[kcol_r]) begin
                           kb_push_r <= 1'b1;
                           // [RQ11] [RQ12] position with status
                           kb_code_r <= {ctrl_s, shift_s, krow_r, kcol_r};
                           st_r <= `KDS_ST_HELD;
                        end else begin
                           st_r <= `KDS_ST_IDLE;
                        end
                     end
                  end
               end
               `KDS_ST_HELD: begin
                  if ((row == krow_r) & rl[kcol_r]) begin
                     st_r <= `KDS_ST_IDLE;
                  end
               end
               default: begin
                  st_r <= `KDS_ST_IDLE;
               end
            endcase
         end else if (~kb_mode) begin
            st_r <= `KDS_ST_IDLE;
         end
      end
   end

   // [RQ13] sensor RAM row copy; reset reads all open
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         for (si = 0; si < 8; si = si + 1) begin
            sram_r[si] <= 8'hFF;
         end
      end else if (row_end & sens_mode) begin
         sram_r[row] <= rl;
      end
   end

   // Error flags and sensor change; set wins over clear
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         // [RQ25] errors and change cleared
         ovr_r <= 1'b0;
         und_r <= 1'b0;
         sens_chg_r <= 1'b0;
      end else begin
         // [RQ16] overrun and underrun
         ovr_r <= (fifo_in_valid & ~fifo_in_ready) | (ovr_r & ~(rd_rise & a0));
         und_r <= (data_pop & ~fifo_out_valid) | (und_r & ~(rd_rise & a0));
         // [RQ19] change in any sensor
         sens_chg_r <= (row_end & sens_mode & (sram_r[row] != rl)) |
                       (sens_chg_r & ~(rd_rise & ~a0 & ~rd_disp_r));
      end
   end

   // Interrupt output
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else if (sens_mode) begin
         o_irq <= sens_chg_r;
      end else begin
         // [RQ18] drops on each queue data read, back if more
         o_irq <= fifo_out_valid & ~data_pop;
      end
   end

   // ==============================================
   // Display refresh
   wire [3:0] dig_mask = kdec ? 4'h3 : (dmode_r[0] ? 4'hF : 4'h7);
   // [RQ8] decoded keyboard shows four digits
   wire [3:0] raddr = (scan_r + dofs_r) & dig_mask;
   wire [7:0] rdat = dram_r[raddr];

   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_scan_line_outputs <= 4'h0;
         o_display_high_nibble_port <= 4'h0;
         o_display_low_nibble_port <= 4'h0;
         o_display_blank_output <= 1'b1;
      end else begin
         // [RQ6] [RQ7] encoded or decoded scan
         o_scan_line_outputs <= kdec ? ~(4'h1 << scan_r[1:0]) : scan_r;
         // [RQ21] high nibble bits 7:4, low 3:0
         o_display_high_nibble_port <= i_blank_high ? 4'h0 : rdat[7:4];
         o_display_low_nibble_port <= i_blank_low ? 4'h0 : rdat[3:0];
         // [RQ22] blank at switch or both blank inputs
         o_display_blank_output <= (sub_r < `KDS_BLANK_TICKS) | (i_blank_high & i_blank_low);
      end
   end
endmodule
`default_nettype wire

// ### tb/kds_top_monitor.sv
// Port checker for the keyboard and display scanner top
`timescale 1ns/100ps
`default_nettype none
module kds_top_monitor (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_cs_n,
   input wire logic i_command_data_select,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [7:0] i_data,
   input wire logic [7:0] o_data,
   input wire logic o_data_oe_n,
   input wire logic [7:0] i_return_line_inputs,
   input wire logic i_shift,
   input wire logic i_control_strobe_input,
   input wire logic i_blank_high,
   input wire logic i_blank_low,
   input wire logic [3:0] o_scan_line_outputs,
   input wire logic [3:0] o_display_high_nibble_port,
   input wire logic [3:0] o_display_low_nibble_port,
   input wire logic o_display_blank_output,
   input wire logic o_irq
);
   logic [7:0] scan_age_r;
   logic [3:0] rd_age_r;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);
   // ==============================================
   // Helper counters
   // Age of the scan row and of the last read release
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         scan_age_r <= 8'h00;
         rd_age_r <= 4'hF;
      end else begin
         scan_age_r <= $changed(o_scan_line_outputs) ? 8'h00 : scan_age_r + {7'h00, scan_age_r != 8'hFF};
         rd_age_r <= $rose(i_rd_n) ? 4'h0 : rd_age_r + {3'h0, rd_age_r != 4'hF};
      end
   end
   // ==============================================
   // Assertions
   // deselected bus off
   AST_DESELECT_OFF: assert property ((i_cs_n)[*5] |-> o_data_oe_n)
      else $error("bus driven while deselected");
   AST_READ_DRIVES: assert property ((!i_cs_n && !i_rd_n)[*5] |-> !o_data_oe_n)
      else $error("bus not driven during read");
   AST_DRIVE_CAUSE: assert property ($fell(o_data_oe_n) |-> $past(!i_rd_n && !i_cs_n, 3))
      else $error("bus driven without read");
   AST_READ_RELEASE: assert property ($rose(i_rd_n) |-> ##[1:5] o_data_oe_n)
      else $error("bus not released after read");
   AST_RESET_QUIET: assert property (disable iff (1'b0) i_reset |=> !o_irq && o_data_oe_n)
      else $error("irq or bus active after reset");
   AST_SCAN_STEP: assert property ($changed(o_scan_line_outputs) |->
      o_scan_line_outputs == $past(o_scan_line_outputs) + 4'h1 || o_scan_line_outputs inside {4'hE, 4'hD, 4'hB, 4'h7})
      else $error("scan lines skipped a row");
   AST_ROW_LENGTH: assert property ($changed(o_scan_line_outputs) &&
      !(o_scan_line_outputs inside {4'hE, 4'hD, 4'hB, 4'h7}) |-> scan_age_r >= 8'h78)
      else $error("scan row too short");
   AST_BLANK_SWITCH: assert property ($changed(o_scan_line_outputs) &&
      !(o_scan_line_outputs inside {4'hE, 4'hD, 4'hB, 4'h7}) |-> ##[0:2] o_display_blank_output)
      else $error("no blank at digit switch");
   AST_BLANK_FORCE: assert property ((i_blank_high && i_blank_low)[*2] |-> o_display_blank_output)
      else $error("blank inputs ignored");
   AST_IRQ_DROP: assert property ($fell(o_irq) |-> rd_age_r <= 4'h8)
      else $error("irq fell without a read");
endmodule
bind kds_top kds_top_monitor mon_u (.i_core_clk, .i_reset, .i_cs_n, .i_command_data_select, .i_rd_n, .i_wr_n,
   .i_data, .o_data, .o_data_oe_n, .i_return_line_inputs, .i_shift, .i_control_strobe_input, .i_blank_high,
   .i_blank_low, .o_scan_line_outputs, .o_display_high_nibble_port, .o_display_low_nibble_port,
   .o_display_blank_output, .o_irq);
`default_nettype wire

// ### tb/kds_host_model.sv
// Host processor bus model for the scanner
`timescale 1ns/100ps
`default_nettype none
module kds_host_model (
   input wire logic i_core_clk,
   input wire logic [7:0] i_rd_data,
   input wire logic i_rd_oe_n,
   output logic o_cs_n,
   output logic o_sel,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic [7:0] o_wr_data
);
   // Bus idle at start
   initial begin
      o_cs_n = 1'b1;
      o_sel = 1'b0;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_wr_data = 8'h00;
   end
   // Wait falling edges
   task automatic idle(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic bus_wr(input logic sel, input logic [7:0] d);
      @(negedge i_core_clk);
      o_cs_n = 1'b0;
      o_sel = sel;
      o_wr_data = d;
      o_wr_n = 1'b0;
      idle(5);
      o_wr_n = 1'b1;
      idle(5);
      o_cs_n = 1'b1;
      o_wr_data = ~d;
      idle(4);
   endtask
   task automatic bus_rd(input logic sel, output logic [7:0] d);
      int n;
      n = 0;
      @(negedge i_core_clk);
      o_cs_n = 1'b0;
      o_sel = sel;
      o_rd_n = 1'b0;
      while (i_rd_oe_n !== 1'b0 && n < 10) begin
         idle(1);
         n++;
      end
      d = (i_rd_oe_n === 1'b0) ? i_rd_data : 8'hXX;
      idle(2);
      o_rd_n = 1'b1;
      idle(5);
      o_cs_n = 1'b1;
      idle(4);
   endtask
endmodule
`default_nettype wire

// ### tb/kds_top_test.sv
// Self-checking bench for the scanner top
`timescale 1ns/100ps
`default_nettype none
module kds_top_test;
   logic clk, rst, cs_n, sel, rd_n, wr_n, oe_n, key_on, shift, ctl, bl_h, bl_l, blank, irq;
   logic [7:0] wdat, rdat, rl_idle, rl, d;
   logic [3:0] scan, hi, lo;
   int n_fail, check_count, cyc, n;
   // Key at row 3 column 5 pulls its line low
   assign rl = (key_on && scan[2:0] == 3'h3) ? 8'hDF : rl_idle;
   kds_top #(.FIFO_DEPTH(8)) dut_u (.i_core_clk(clk), .i_reset(rst), .i_cs_n(cs_n), .i_command_data_select(sel),
      .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(wdat), .o_data(rdat), .o_data_oe_n(oe_n), .i_return_line_inputs(rl),
      .i_shift(shift), .i_control_strobe_input(ctl), .i_blank_high(bl_h), .i_blank_low(bl_l),
      .o_scan_line_outputs(scan), .o_display_high_nibble_port(hi), .o_display_low_nibble_port(lo),
      .o_display_blank_output(blank), .o_irq(irq));
   kds_host_model host_u (.i_core_clk(clk), .i_rd_data(rdat), .i_rd_oe_n(oe_n), .o_cs_n(cs_n), .o_sel(sel),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .o_wr_data(wdat));
   // ==============================================
   // Clock and cycle limit
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         $display("[ERR] %0t cycle limit reached", $time);
         end_sim();
      end
   end
   // ==============================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic s, input logic [7:0] exp);
      host_u.bus_rd(s, d);
      chk(d, exp);
   endtask
   task automatic wait_irq;
      n = 0;
      while (irq !== 1'b1 && n < 12000) begin
         @(negedge clk);
         n++;
      end
   endtask
   // Wait until masked scan lines show a value
   task automatic wait_scan(input logic [3:0] m, input logic [3:0] v);
      n = 0;
      while ((scan & m) !== v && n < 4000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic end_sim;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==============================================
   // Test sequence
   initial begin
      rst = 1'b1;
      key_on = 1'b0;
      shift = 1'b1;
      ctl = 1'b1;
      bl_h = 1'b0;
      bl_l = 1'b0;
      rl_idle = 8'hFF;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk({7'h0, irq}, 8'h00);
      chk({7'h0, oe_n}, 8'h01);
      // First row lasts 64 ticks of 31 clocks
      wait_scan(4'hF, 4'h1);
      chk({7'h0, (n >= 1983 && n <= 1987)}, 8'h01);
      rd(1'b1, 8'h00);
      host_u.bus_wr(1'b1, 8'h22);
      shift = 1'b0;
      key_on = 1'b1;
      wait_irq();
      chk({7'h0, irq}, 8'h01);
      key_on = 1'b0;
      rd(1'b1, 8'h01);
      host_u.bus_wr(1'b1, 8'h40);
      rd(1'b0, 8'h9D);
      chk({7'h0, irq}, 8'h00);
      shift = 1'b1;
      $display("test key done");
      host_u.bus_wr(1'b1, 8'h06);
      for (int i = 0; i < 9; i++) begin
         rl_idle = 8'hA0 + i[7:0];
         ctl = 1'b0;
         host_u.idle(5);
         ctl = 1'b1;
         host_u.idle(5);
      end
      rl_idle = 8'hFF;
      chk({7'h0, irq}, 8'h01);
      rd(1'b1, 8'h28);
      host_u.bus_wr(1'b1, 8'h40);
      for (int i = 0; i < 8; i++) rd(1'b0, 8'hA0 + i[7:0]);
      chk({7'h0, irq}, 8'h00);
      host_u.bus_rd(1'b0, d);
      rd(1'b1, 8'h10);
      rd(1'b1, 8'h00);
      $display("test queue done");
      host_u.bus_wr(1'b1, 8'h90);
      host_u.bus_wr(1'b0, 8'hA5);
      host_u.bus_wr(1'b0, 8'h3C);
      host_u.bus_wr(1'b1, 8'h70);
      rd(1'b0, 8'hA5);
      rd(1'b0, 8'h3C);
      host_u.bus_wr(1'b1, 8'h61);
      rd(1'b0, 8'h3C);
      rd(1'b0, 8'h3C);
      // Nibble ports show digit 0 on its row
      wait_scan(4'h7, 4'h0);
      chk({hi, lo}, 8'hA5);
      $display("test display done");
      host_u.bus_wr(1'b1, 8'h04);
      key_on = 1'b1;
      wait_irq();
      chk({7'h0, irq}, 8'h01);
      host_u.bus_wr(1'b1, 8'h43);
      rd(1'b0, 8'hDF);
      chk({7'h0, irq}, 8'h00);
      key_on = 1'b0;
      wait_irq();
      chk({7'h0, irq}, 8'h01);
      rd(1'b0, 8'hFF);
      chk({7'h0, irq}, 8'h00);
      $display("test sensor done");
      bl_h = 1'b1;
      bl_l = 1'b1;
      repeat (4) @(negedge clk);
      chk({7'h0, blank}, 8'h01);
      chk({hi, lo}, 8'h00);
      bl_h = 1'b0;
      bl_l = 1'b0;
      host_u.bus_wr(1'b1, 8'h01);
      repeat (300) @(negedge clk);
      chk({7'h0, scan inside {4'hE, 4'hD, 4'hB, 4'h7}}, 8'h01);
      // Decoded row 1 refreshes digit 1 only
      wait_scan(4'hF, 4'hD);
      chk({hi, lo}, 8'h3C);
      $display("test scan done");
      end_sim();
   end
endmodule
`default_nettype wire
